// ===== src/clm_params.svh
// constants for the compact load/move execute block
// assumes inclusion by bare name from the package and clm_exec
`ifndef CLM_PARAMS_SVH
`define CLM_PARAMS_SVH

// --------------------------------------------------------------------
// instruction field positions
// --------------------------------------------------------------------
`define CLM_PREFIX_MSB    31
`define CLM_PREFIX_LSB    27
`define CLM_MAJOR_MSB     15
`define CLM_MAJOR_LSB     11
`define CLM_FLD_A_MSB     10
`define CLM_FLD_A_LSB     8
`define CLM_FLD_B_MSB     7
`define CLM_FLD_B_LSB     5
`define CLM_FUNC_MSB      4
`define CLM_FUNC_LSB      0

// --------------------------------------------------------------------
// encodings
// --------------------------------------------------------------------
`define CLM_EXT_PREFIX    5'h1e
`define CLM_OP_STACK_LD   5'h12
`define CLM_OP_ZEXT_LD    5'h17
`define CLM_OP_TWO_REG    5'h1d
`define CLM_OP_IMM8       5'h0c
`define CLM_FN_COPY_TOP   5'h10
`define CLM_FN_COPY_BOT   5'h12
`define CLM_SUB_TO_FULL   3'h5
`define CLM_SUB_FROM_FULL 3'h7
`define CLM_ZERO_FIELD    3'h0
`define CLM_STACK_REG     5'h1d
`define CLM_ZERO_REG      5'h00

// --------------------------------------------------------------------
// reset values and register count
// --------------------------------------------------------------------
`define CLM_GPR_RST       64'h0000_0000_0000_0000
`define CLM_NUM_GPR       32

`endif

// ===== src/clm_pkg.sv
// types shared by the compact load/move execute block
// assumes clm_params.svh sits on the include path
package clm_pkg;
`include "clm_params.svh"

   // -----------------------------------------------------------------
   // enumerations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLM_ST_IDLE,
      CLM_ST_XLATE,
      CLM_ST_MEM
   } clm_state_e;

   typedef enum logic [2:0] {
      CLM_OP_NONE,
      CLM_OP_LD_STACK,
      CLM_OP_LD_ZEXT,
      CLM_OP_CP_TOP,
      CLM_OP_CP_BOT,
      CLM_OP_MV_TO_FULL,
      CLM_OP_MV_FROM_FULL,
      CLM_OP_RESERVED
   } clm_op_e;

   typedef enum logic [2:0] {
      CLM_EXC_NONE,
      CLM_EXC_TLB_REFILL,
      CLM_EXC_TLB_INVALID,
      CLM_EXC_BUS_ERROR,
      CLM_EXC_ADDR_ERROR,
      CLM_EXC_RESERVED
   } clm_exc_e;

   typedef logic [4:0] clm_reg_t;

   // -----------------------------------------------------------------
   // 3-bit field to full register number
   // -----------------------------------------------------------------
   function automatic clm_reg_t clm_xlat(input logic [2:0] code);
      clm_reg_t r;
      r = {2'b00, code};
      if (code[2:1] == 2'b00) begin
         r = {4'h8, code[0]};
      end
      return r;
   endfunction
endpackage

// ===== src/clm_word_pick.sv
// picks the addressed 32-bit word out of a loaded doubleword
// assumes the address is already known to be word aligned
`timescale 1ns/100ps
module clm_word_pick
   import clm_pkg::*;
(
   input  wire logic [63:0] dword,
   input  wire logic [2:0]  vaddr_lo,
   input  wire logic        cpu_byte_order,
   input  wire logic        zero_ext,
   output logic      [63:0] result
);
   // -----------------------------------------------------------------
   // lane select
   // -----------------------------------------------------------------
   wire [2:0]  byte_idx = vaddr_lo ^ {cpu_byte_order, 2'b00};
   wire [63:0] shifted  = dword >> {byte_idx, 3'b000};
   wire [31:0] word     = shifted[31:0];
   wire [31:0] upper    = zero_ext ? 32'h0000_0000 : {32{word[31]}};

   assign result = {upper, word};
endmodule

// ===== src/clm_exec.sv
// decode and execute of compact stack/zero-extend loads and moves
// assumes one instruction presented at a time with its prefix halfword
`timescale 1ns/100ps
`include "clm_params.svh"
module clm_exec
   import clm_pkg::*;
#(
   parameter int PADDR_W   = 40,
   parameter int CCA_W     = 3,
   parameter bit HAS_64BIT = 1'b1
)(
   input  wire logic                 CLOCK,
   input  wire logic                 RST_B,
   input  wire logic                 INSTR_VALID,
   input  wire logic                 INSTR_EXT,
   input  wire logic [31:0]          INSTR,
   output logic                      INSTR_READY,
   output logic                      DONE,
   output logic                      EXC_VALID,
   output clm_exc_e                  EXC_CODE,
   output logic [63:0]               EXC_VADDR,
   input  wire logic                 ENDIAN_SWAP_MODE,
   input  wire logic                 CPU_BYTE_ORDER,
   input  wire logic [63:0]          PRODUCT_TOP_HALF,
   input  wire logic [63:0]          PRODUCT_BOTTOM_HALF,
   input  wire logic                 PRODUCT_BUSY,
   output logic                      XL_REQ,
   output logic [63:0]               XL_VADDR,
   input  wire logic                 XL_ACK,
   input  wire logic [PADDR_W-1:0]   XL_PADDR,
   input  wire logic [CCA_W-1:0]     XL_CACHEABILITY_ATTRIBUTE,
   input  wire logic                 XL_REFILL,
   input  wire logic                 XL_INVALID,
   output logic                      MEM_REQ,
   output logic [PADDR_W-1:0]        MEM_PADDR,
   output logic [CCA_W-1:0]          MEM_CACHEABILITY_ATTRIBUTE,
   input  wire logic                 MEM_ACK,
   input  wire logic [63:0]          MEM_DATA,
   input  wire logic                 MEM_BUS_ERR,
   output logic                      WB_VALID,
   output logic [4:0]                WB_ADDR,
   output logic [63:0]               WB_DATA,
   input  wire logic [4:0]           DBG_RADDR,
   output logic [63:0]               DBG_RDATA
);
   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   if (PADDR_W < 3 || PADDR_W > 64) begin : g_bad_paddr
      $error("clm_exec: PADDR_W must lie in 3..64");
   end
   if (CCA_W < 1) begin : g_bad_cca
      $error("clm_exec: CCA_W must be at least 1");
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   clm_state_e       state;
   clm_state_e       next_state;
   logic [63:0]      gpr [`CLM_NUM_GPR];
   logic [63:0]      ld_vaddr;
   clm_reg_t         ld_dest;
   logic             ld_zext;

   // -----------------------------------------------------------------
   // field extraction
   // -----------------------------------------------------------------
   wire [15:0] hw       = INSTR[15:0];
   wire [4:0]  prefix   = INSTR[`CLM_PREFIX_MSB:`CLM_PREFIX_LSB];
   wire [4:0]  major    = hw[`CLM_MAJOR_MSB:`CLM_MAJOR_LSB];
   wire [2:0]  fld_a    = hw[`CLM_FLD_A_MSB:`CLM_FLD_A_LSB];
   wire [2:0]  fld_b    = hw[`CLM_FLD_B_MSB:`CLM_FLD_B_LSB];
   wire [4:0]  func     = hw[`CLM_FUNC_MSB:`CLM_FUNC_LSB];
   wire [2:0]  third_reg_field = hw[2:0];
   wire [4:0]  full_reg_field  = hw[4:0];
   wire        ext_ok   = INSTR_EXT && (prefix == `CLM_EXT_PREFIX);
   wire        short_ok = !INSTR_EXT;
   wire [15:0] imm16    = {INSTR[20:16], INSTR[26:21], INSTR[4:0]};

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire is_stack_ld = ext_ok && (major == `CLM_OP_STACK_LD)
                      && (fld_b == `CLM_ZERO_FIELD);
   wire is_zext_ld  = (ext_ok || short_ok)
                      && (major == `CLM_OP_ZEXT_LD);
   wire is_two_reg  = short_ok && (major == `CLM_OP_TWO_REG)
                      && (fld_b == `CLM_ZERO_FIELD);
   wire is_cp_top   = is_two_reg && (func == `CLM_FN_COPY_TOP);
   wire is_cp_bot   = is_two_reg && (func == `CLM_FN_COPY_BOT);
   wire is_imm8     = short_ok && (major == `CLM_OP_IMM8);
   wire is_to_full  = is_imm8 && (fld_a == `CLM_SUB_TO_FULL);
   wire is_from_full = is_imm8 && (fld_a == `CLM_SUB_FROM_FULL);

   clm_op_e dec_op;
   assign dec_op = is_stack_ld                 ? CLM_OP_LD_STACK
                 : (is_zext_ld && !HAS_64BIT)  ? CLM_OP_RESERVED
                 : is_zext_ld                  ? CLM_OP_LD_ZEXT
                 : is_cp_top                   ? CLM_OP_CP_TOP
                 : is_cp_bot                   ? CLM_OP_CP_BOT
                 : is_to_full                  ? CLM_OP_MV_TO_FULL
                 : is_from_full                ? CLM_OP_MV_FROM_FULL
                 :                               CLM_OP_NONE;

   // -----------------------------------------------------------------
   // load address
   // -----------------------------------------------------------------
   wire [63:0] sext_imm  = {{48{imm16[15]}}, imm16};
   wire [63:0] short_off = {57'h0, hw[4:0], 2'b00};
   wire [63:0] stack_base = gpr[`CLM_STACK_REG];
   wire [63:0] zext_base  = gpr[clm_xlat(fld_a)];
   wire [63:0] ld_base   = is_stack_ld ? stack_base : zext_base;
   wire [63:0] ld_off    = (is_stack_ld || ext_ok) ? sext_imm : short_off;
   wire [63:0] new_vaddr = ld_base + ld_off;
   wire        misalign  = new_vaddr[1:0] != 2'b00;
   wire        is_load   = (dec_op == CLM_OP_LD_STACK)
                           || (dec_op == CLM_OP_LD_ZEXT);
   clm_reg_t   new_dest;
   assign new_dest = is_stack_ld ? clm_xlat(fld_a)
                                 : clm_xlat(fld_b);

   // -----------------------------------------------------------------
   // move sources and destinations
   // -----------------------------------------------------------------
   // products are sampled only when taken; a later overwrite cannot reach back
   wire [63:0] top_val   = PRODUCT_TOP_HALF;
   wire [63:0] bot_val   = PRODUCT_BOTTOM_HALF;
   wire [4:0]  to_full_dst = {hw[4:3], fld_b};
   wire [63:0] to_full_val = gpr[clm_xlat(third_reg_field)];
   wire [63:0] from_full_val = gpr[full_reg_field];

   logic        mv_en;
   clm_reg_t    mv_dst;
   logic [63:0] mv_val;
   always_comb begin
      mv_en  = 1'b1;
      mv_dst = clm_xlat(fld_a);
      mv_val = top_val;
      case (dec_op)
         CLM_OP_CP_TOP: begin
            mv_val = top_val;
         end
         CLM_OP_CP_BOT: begin
            mv_val = bot_val;
         end
         CLM_OP_MV_TO_FULL: begin
            mv_dst = to_full_dst;
            mv_val = to_full_val;
         end
         CLM_OP_MV_FROM_FULL: begin
            mv_dst = clm_xlat(fld_b);
            mv_val = from_full_val;
         end
         default: begin
            mv_en = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // handshake terms
   // -----------------------------------------------------------------
   wire is_copy  = (dec_op == CLM_OP_CP_TOP) || (dec_op == CLM_OP_CP_BOT);
   // a pending multiply interlocks the copy instead of asking software to wait
   wire take     = INSTR_VALID && INSTR_READY
                   && !(is_copy && PRODUCT_BUSY);
   wire xl_fault = XL_REFILL || XL_INVALID;
   wire xl_done  = (state == CLM_ST_XLATE) && XL_ACK;
   wire mem_done = (state == CLM_ST_MEM) && MEM_ACK;
   wire [PADDR_W-1:0] swapped_paddr = XL_PADDR ^ {{(PADDR_W-3){1'b0}},
                                      ENDIAN_SWAP_MODE, 2'b00};

   logic [63:0] picked;
   clm_word_pick u_pick (
      .dword          (MEM_DATA),
      .vaddr_lo       (ld_vaddr[2:0]),
      .cpu_byte_order (CPU_BYTE_ORDER),
      .zero_ext       (ld_zext),
      .result         (picked)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         CLM_ST_IDLE: begin
            if (take && is_load && !misalign) begin
               next_state = CLM_ST_XLATE;
            end
         end
         CLM_ST_XLATE: begin
            if (XL_ACK) begin
               next_state = xl_fault ? CLM_ST_IDLE : CLM_ST_MEM;
            end
         end
         CLM_ST_MEM: begin
            if (MEM_ACK) begin
               next_state = CLM_ST_IDLE;
            end
         end
         default: begin
            next_state = CLM_ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // exceptions and completion
   // -----------------------------------------------------------------
   clm_exc_e next_exc;
   always_comb begin
      next_exc = CLM_EXC_NONE;
      if (take && is_load && misalign) begin
         next_exc = CLM_EXC_ADDR_ERROR;
      end else if (take && dec_op == CLM_OP_RESERVED) begin
         next_exc = CLM_EXC_RESERVED;
      end else if (xl_done && XL_REFILL) begin
         next_exc = CLM_EXC_TLB_REFILL;
      end else if (xl_done && XL_INVALID) begin
         next_exc = CLM_EXC_TLB_INVALID;
      end else if (mem_done && MEM_BUS_ERR) begin
         next_exc = CLM_EXC_BUS_ERROR;
      end
   end

   wire next_done = (take && !(is_load && !misalign))
                    || (xl_done && xl_fault) || mem_done;
   wire [63:0] next_exc_vaddr = (state == CLM_ST_IDLE) ? new_vaddr : ld_vaddr;

   // -----------------------------------------------------------------
   // register write
   // -----------------------------------------------------------------
   wire         ld_wb      = mem_done && !MEM_BUS_ERR;
   wire         next_wb_en = ld_wb || (take && mv_en);
   clm_reg_t    next_wb_addr;
   assign next_wb_addr = ld_wb ? ld_dest : mv_dst;
   wire [63:0]  next_wb_data = ld_wb ? picked : mv_val;
   // register zero swallows every write, which makes 0x6500 a no-op
   wire         wb_commit  = next_wb_en
                             && (next_wb_addr != `CLM_ZERO_REG);

   // -----------------------------------------------------------------
   // flops
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         state       <= CLM_ST_IDLE;
         INSTR_READY <= 1'b0;
         DONE        <= 1'b0;
         EXC_VALID   <= 1'b0;
         EXC_CODE    <= CLM_EXC_NONE;
         EXC_VADDR   <= 64'h0;
      end else begin
         state       <= next_state;
         INSTR_READY <= (next_state == CLM_ST_IDLE);
         DONE        <= next_done;
         EXC_VALID   <= (next_exc != CLM_EXC_NONE);
         EXC_CODE    <= next_exc;
         EXC_VADDR   <= (next_exc != CLM_EXC_NONE) ? next_exc_vaddr : EXC_VADDR;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ld_vaddr <= 64'h0;
         ld_dest  <= `CLM_ZERO_REG;
         ld_zext  <= 1'b0;
      end else if (take && is_load) begin
         ld_vaddr <= new_vaddr;
         ld_dest  <= new_dest;
         ld_zext  <= (dec_op == CLM_OP_LD_ZEXT);
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         XL_REQ   <= 1'b0;
         XL_VADDR <= 64'h0;
      end else begin
         XL_REQ   <= (next_state == CLM_ST_XLATE);
         XL_VADDR <= (take && is_load) ? new_vaddr : XL_VADDR;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         MEM_REQ                    <= 1'b0;
         MEM_PADDR                  <= '0;
         MEM_CACHEABILITY_ATTRIBUTE <= '0;
      end else begin
         MEM_REQ <= (next_state == CLM_ST_MEM);
         if (xl_done && !xl_fault) begin
            MEM_PADDR                  <= swapped_paddr;
            MEM_CACHEABILITY_ATTRIBUTE <= XL_CACHEABILITY_ATTRIBUTE;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         WB_VALID <= 1'b0;
         WB_ADDR  <= `CLM_ZERO_REG;
         WB_DATA  <= 64'h0;
      end else begin
         WB_VALID <= wb_commit;
         WB_ADDR  <= wb_commit ? next_wb_addr : WB_ADDR;
         WB_DATA  <= wb_commit ? next_wb_data : WB_DATA;
      end
   end

   // -----------------------------------------------------------------
   // general registers
   // -----------------------------------------------------------------
   // full reset keeps the debug read port defined; costs area, not timing
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < `CLM_NUM_GPR; i++) begin
            gpr[i] <= `CLM_GPR_RST;
         end
      end else if (wb_commit) begin
         gpr[next_wb_addr] <= next_wb_data;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         DBG_RDATA <= 64'h0;
      end else begin
         DBG_RDATA <= gpr[DBG_RADDR];
      end
   end
endmodule

// ===== tb/clm_exec_monitor.sv
// checker for the compact load/move block, sees top ports only
// assumes the bind below and one clock domain
`timescale 1ns/100ps
module clm_exec_monitor
   import clm_pkg::*;
#(
   parameter int PADDR_W = 40,
   parameter int CCA_W   = 3
)(
   input wire logic               CLOCK,
   input wire logic               RST_B,
   input wire logic               DONE,
   input wire logic               EXC_VALID,
   input wire clm_exc_e           EXC_CODE,
   input wire logic               ENDIAN_SWAP_MODE,
   input wire logic               XL_REQ,
   input wire logic [63:0]        XL_VADDR,
   input wire logic               XL_ACK,
   input wire logic [PADDR_W-1:0] XL_PADDR,
   input wire logic [CCA_W-1:0]   XL_CACHEABILITY_ATTRIBUTE,
   input wire logic               XL_REFILL,
   input wire logic               XL_INVALID,
   input wire logic               MEM_REQ,
   input wire logic [PADDR_W-1:0] MEM_PADDR,
   input wire logic [CCA_W-1:0]   MEM_CACHEABILITY_ATTRIBUTE,
   input wire logic               MEM_ACK,
   input wire logic               MEM_BUS_ERR,
   input wire logic               WB_VALID,
   input wire logic [4:0]         WB_ADDR
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   AST_XL_HOLD: assert property (XL_REQ && !XL_ACK |=> XL_REQ && $stable(XL_VADDR))
      else $error("xlate request not held");
   AST_XL_ALIGN: assert property (XL_REQ |-> XL_VADDR[1:0] == 2'h0)
      else $error("misaligned address translated");
   AST_PA_FLIP: assert property ($rose(MEM_REQ) |->
      MEM_PADDR == ($past(XL_PADDR) ^ PADDR_W'({ENDIAN_SWAP_MODE, 2'h0})))
      else $error("memory address bit 2 wrong");
   AST_CCA_PASS: assert property ($rose(MEM_REQ) |->
      MEM_CACHEABILITY_ATTRIBUTE == $past(XL_CACHEABILITY_ATTRIBUTE))
      else $error("attribute not passed on");
   AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_PADDR))
      else $error("memory request not held");
   AST_XL_FAULT: assert property (XL_REQ && XL_ACK && (XL_REFILL || XL_INVALID) |=>
      EXC_VALID && !MEM_REQ
      && EXC_CODE == ($past(XL_REFILL) ? CLM_EXC_TLB_REFILL : CLM_EXC_TLB_INVALID))
      else $error("translation fault mishandled");
   AST_BUS_FAULT: assert property (MEM_REQ && MEM_ACK && MEM_BUS_ERR |=>
      EXC_VALID && EXC_CODE == CLM_EXC_BUS_ERROR && !WB_VALID)
      else $error("bus error mishandled");
   AST_LOAD_WB: assert property (MEM_REQ && MEM_ACK && !MEM_BUS_ERR |=> DONE && WB_VALID)
      else $error("load result not written");
   AST_NO_ZERO: assert property (WB_VALID |-> DONE && WB_ADDR != 5'h0)
      else $error("register zero written");
   AST_EXC_ONLY: assert property (EXC_VALID |-> DONE && !WB_VALID)
      else $error("write beside exception");
   cover property (XL_REQ && XL_ACK && !XL_REFILL && !XL_INVALID);
   cover property (EXC_VALID && EXC_CODE == CLM_EXC_ADDR_ERROR);
   cover property (MEM_REQ && MEM_ACK && ENDIAN_SWAP_MODE);
endmodule

bind clm_exec clm_exec_monitor #(.PADDR_W(PADDR_W), .CCA_W(CCA_W)) clm_exec_monitor_i (
   .CLOCK, .RST_B, .DONE, .EXC_VALID, .EXC_CODE, .ENDIAN_SWAP_MODE, .XL_REQ, .XL_VADDR,
   .XL_ACK, .XL_PADDR, .XL_CACHEABILITY_ATTRIBUTE, .XL_REFILL, .XL_INVALID, .MEM_REQ,
   .MEM_PADDR, .MEM_CACHEABILITY_ATTRIBUTE, .MEM_ACK, .MEM_BUS_ERR, .WB_VALID, .WB_ADDR);

// ===== tb/clm_xlate_mem_model.sv
// translation and memory stage model facing the block
// assumes physical = virtual + 0x100, data derived from address
`timescale 1ns/100ps
module clm_xlate_mem_model #(
   parameter int PADDR_W = 40,
   parameter int CCA_W   = 3
)(
   input  wire logic               CLOCK,
   input  wire logic [1:0]         FAULT_SEL,
   input  wire logic               XL_REQ,
   input  wire logic [63:0]        XL_VADDR,
   output logic                    XL_ACK,
   output logic [PADDR_W-1:0]      XL_PADDR,
   output logic [CCA_W-1:0]        XL_CACHEABILITY_ATTRIBUTE,
   output logic                    XL_REFILL,
   output logic                    XL_INVALID,
   input  wire logic               MEM_REQ,
   input  wire logic [PADDR_W-1:0] MEM_PADDR,
   output logic                    MEM_ACK,
   output logic [63:0]             MEM_DATA,
   output logic                    MEM_BUS_ERR
);
   integer seed = 21459;
   int     wait_n = 0;
   // ---------------------------------------------------------------
   // answers
   // ---------------------------------------------------------------
   initial begin
      {XL_ACK, XL_PADDR, XL_CACHEABILITY_ATTRIBUTE, MEM_ACK, MEM_DATA} = '0;
      forever begin
         @(posedge CLOCK);
         #1;
         // junk address, data and fault flags outside answers so none of them can pass stale
         {XL_ACK, MEM_ACK} = 2'h0;
         {XL_REFILL, XL_INVALID, MEM_BUS_ERR} = 3'($random(seed));
         XL_PADDR = ~XL_PADDR;
         MEM_DATA = ~MEM_DATA;
         if (wait_n > 0) begin
            wait_n--;
         end else if (XL_REQ) begin
            XL_ACK = 1'b1;
            XL_PADDR = PADDR_W'(XL_VADDR + 64'h100);
            XL_CACHEABILITY_ATTRIBUTE = CCA_W'($random(seed));
            {XL_REFILL, XL_INVALID} = {FAULT_SEL == 2'h1, FAULT_SEL == 2'h2};
            wait_n = $random(seed) & 3;
         end else if (MEM_REQ) begin
            MEM_ACK = 1'b1;
            MEM_DATA = {~MEM_PADDR[31:0], MEM_PADDR[31:0] ^ 32'h9e37_79b9};
            MEM_BUS_ERR = FAULT_SEL == 2'h3;
            wait_n = $random(seed) & 3;
         end
      end
   end
endmodule

// ===== tb/clm_exec_test.sv
// self-checking bench for clm_exec with the stage model
// assumes default design parameters
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module clm_exec_test
   import clm_pkg::*;
;
   logic CLOCK, RST_B = 0, INSTR_VALID = 0, INSTR_EXT = 0, ENDIAN_SWAP_MODE = 0;
   logic CPU_BYTE_ORDER = 0, PRODUCT_BUSY = 0, sw, bo;
   logic INSTR_READY, DONE, EXC_VALID, XL_REQ, XL_ACK, XL_REFILL, XL_INVALID;
   logic MEM_REQ, MEM_ACK, MEM_BUS_ERR, WB_VALID;
   logic [31:0] INSTR = 0;
   logic [63:0] PRODUCT_TOP_HALF = 0, PRODUCT_BOTTOM_HALF = 0, top, bot;
   logic [63:0] EXC_VADDR, XL_VADDR, MEM_DATA, WB_DATA, DBG_RDATA, gpr [32];
   logic [39:0] XL_PADDR, MEM_PADDR;
   logic [2:0]  XL_CACHEABILITY_ATTRIBUTE, MEM_CACHEABILITY_ATTRIBUTE;
   logic [4:0]  WB_ADDR, DBG_RADDR = 0;
   logic [1:0]  fault_sel = 0, flt;
   clm_exc_e    EXC_CODE;
   logic [73:0] notes [$];
   logic [73:0] got;
   logic [63:0] vas [$];
   wire  [73:0] seen = {EXC_VALID, EXC_CODE, WB_VALID, WB_VALID ? {WB_ADDR, WB_DATA} : 69'h0};
   integer      seed = 21459;
   int          num_errors = 0, n_checks = 0;

   clm_exec clm_exec_i (.CLOCK, .RST_B, .INSTR_VALID, .INSTR_EXT, .INSTR, .INSTR_READY,
      .DONE, .EXC_VALID, .EXC_CODE, .EXC_VADDR, .ENDIAN_SWAP_MODE, .CPU_BYTE_ORDER,
      .PRODUCT_TOP_HALF, .PRODUCT_BOTTOM_HALF, .PRODUCT_BUSY, .XL_REQ, .XL_VADDR, .XL_ACK,
      .XL_PADDR, .XL_CACHEABILITY_ATTRIBUTE, .XL_REFILL, .XL_INVALID, .MEM_REQ, .MEM_PADDR,
      .MEM_CACHEABILITY_ATTRIBUTE, .MEM_ACK, .MEM_DATA, .MEM_BUS_ERR, .WB_VALID, .WB_ADDR,
      .WB_DATA, .DBG_RADDR, .DBG_RDATA);
   clm_xlate_mem_model clm_xlate_mem_model_i (.CLOCK, .FAULT_SEL(fault_sel), .XL_REQ,
      .XL_VADDR, .XL_ACK, .XL_PADDR, .XL_CACHEABILITY_ATTRIBUTE, .XL_REFILL, .XL_INVALID,
      .MEM_REQ, .MEM_PADDR, .MEM_ACK, .MEM_DATA, .MEM_BUS_ERR);

   // ---------------------------------------------------------------
   // model helpers and driver
   // ---------------------------------------------------------------
   function automatic clm_reg_t map3(input logic [2:0] c);
      return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction
   function logic [73:0] wb(input clm_reg_t a, input logic [63:0] d);
      if (a == 5'h0) return 74'h0;
      gpr[a] = d;
      return {5'h1, a, d};
   endfunction
   task automatic issue(input logic ext, input logic [31:0] ins, input logic [73:0] note);
      logic taken;
      taken = 1'b0;
      for (int n = 0; n < 40 && !taken; n++) begin
         @(negedge CLOCK);
         {INSTR_VALID, INSTR_EXT, INSTR, PRODUCT_TOP_HALF} = {1'b1, ext, ins, top};
         PRODUCT_BOTTOM_HALF = bot;
         if (INSTR_READY) {ENDIAN_SWAP_MODE, CPU_BYTE_ORDER, fault_sel} = {sw, bo, flt};
         PRODUCT_BUSY = ($random(seed) & 3) == 0;
         taken = INSTR_READY && !(PRODUCT_BUSY && ins[15:11] == 5'h1d);
         @(posedge CLOCK);
      end
      notes.push_back(note);
   endtask
   task automatic load(input int k, input logic [2:0] f1, input logic [2:0] f2,
                       input logic [15:0] im);
      logic [63:0] va, w;
      logic [39:0] pa;
      va = (k == 2) ? gpr[map3(f1)] + {im[4:0], 2'h0}
         : gpr[k == 0 ? 5'd29 : map3(f1)] + {{48{im[15]}}, im};
      pa = 40'(va + 64'h100) ^ {sw, 2'h0};
      w = {~pa[31:0], pa[31:0] ^ 32'h9e37_79b9} >> (8 * (va[2:0] ^ {bo, 2'h0}));
      w[63:32] = (k == 0) ? {32{w[31]}} : 32'h0;
      if (va[1:0] != 2'h0 || flt != 2'h0) vas.push_back(va);
      if (va[1:0] != 2'h0) issue(k != 2, {k == 2 ? 16'h0 : {5'h1e, im[10:5], im[15:11]},
         k == 0 ? 5'h12 : 5'h17, f1, k == 0 ? 3'h0 : f2, im[4:0]}, {1'b1, 3'h4, 70'h0});
      else issue(k != 2, {k == 2 ? 16'h0 : {5'h1e, im[10:5], im[15:11]},
         k == 0 ? 5'h12 : 5'h17, f1, k == 0 ? 3'h0 : f2, im[4:0]},
         flt != 2'h0 ? {2'h2, flt, 70'h0} : wb(map3(k == 0 ? f1 : f2), w));
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, result watcher, scenarios
   // ---------------------------------------------------------------
   initial begin
      CLOCK = 0;
      forever #5 CLOCK = ~CLOCK;
   end
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   always @(negedge CLOCK) begin
      if (DONE === 1'b1) begin
         got = notes.size() ? notes.pop_front() : 74'h1;
         `CHK(seen, got)
         if (EXC_VALID === 1'b1) `CHK(EXC_VADDR, vas[0])
         if (EXC_VALID === 1'b1) vas.delete(0);
      end
   end
   initial begin
      {sw, bo, flt, top, bot} = '0;
      foreach (gpr[r]) gpr[r] = 64'h0;
      repeat (3) @(posedge CLOCK);
      @(negedge CLOCK) RST_B = 1'b1;
      // products change every instruction, copies must keep the taken value
      for (int i = 0; i < 16; i++) begin
         top = {$random(seed), $random(seed)} & ~64'h3;
         bot = {$random(seed), $random(seed)} & ~64'h3;
         issue(0, {16'h0, 5'h1d, i[3:1], 3'h0, i[0] ? 5'h12 : 5'h10},
            wb(map3(i[3:1]), i[0] ? bot : top));
      end
      $display("copy test done");
      for (int i = 0; i < 32; i++) begin
         flt = 2'($random(seed));
         issue(0, {16'h0, 5'h0c, 3'h5, i[2:0], i[4:3], flt, 1'b0},
            wb(5'(i), gpr[map3({flt, 1'b0})]));
         issue(0, {16'h0, 5'h0c, 3'h7, i[2:0], 5'(31 - i)},
            wb(map3(i[2:0]), gpr[31 - i]));
      end
      flt = 2'h0;
      issue(0, 32'h0000_6500, 74'h0);
      issue(0, 32'h0000_9000, 74'h0);
      $display("move test done");
      for (int i = 0; i < 60; i++) begin
         {sw, bo, top} = {2'($random(seed)), $random(seed), $random(seed)};
         flt = top[9:8] == 2'h0 ? top[1:0] : 2'h0;
         if (top[7:6] != 2'h0) top[17:16] = 2'h0;
         load(i % 3, top[12:10], top[15:13], top[31:16]);
      end
      @(negedge CLOCK) INSTR_VALID = 1'b0;
      for (int i = 0; i < 100 && notes.size() > 0; i++) @(negedge CLOCK);
      `CHK(notes.size(), 0)
      $display("load test done");
      for (int r = 0; r < 32; r++) begin
         @(negedge CLOCK) DBG_RADDR = 5'(r);
         @(negedge CLOCK) `CHK(DBG_RDATA, gpr[r])
      end
      $display("register readback done");
      stop_test();
   end
endmodule
